// File: hdl/pbs_defines.svh
// Constants of the banked status and control register group
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH
// Register indices; byte address is four times the index
`define PBS_IDX_CFG 8'he0
`define PBS_IDX_TB1 8'he1
`define PBS_IDX_TB4 8'he4
`define PBS_IDX_DOM 8'he5
`define PBS_IDX_A4LO 8'he6
`define PBS_IDX_A4HI 8'he7
`define PBS_IDX_WARN 8'he8
`define PBS_IDX_STAT 8'he9
`define PBS_IDX_MASK 8'hea
// Reset values
`define PBS_RST_CFG 8'h00
`define PBS_RST_TEMPERATURE_REFERENCE 7'h48
`define PBS_RST_DOM 8'h00
`define PBS_RST_WARN 8'h00
// Fields of the warning reset value; a literal cannot be bit-selected
`define PBS_RST_BANK 1'b0
`define PBS_RST_SPEED 2'h0
// Writable bits
`define PBS_DOM_WMASK 8'hf2
// Warning register fields
`define PBS_BANK_BIT 3
`define PBS_SPEED_MSB 1
`define PBS_SPEED_LSB 0
// Target address of agent 1; agents follow consecutively
`define PBS_AGENT_BASE 8'h30
// Clock and bus bit rates
`define PBS_CLK_KHZ 100000
`define PBS_RATE0_KHZ 1500
`define PBS_RATE1_KHZ 750
`define PBS_RATE2_KHZ 375
`define PBS_RATE3_KHZ 187
`define PBS_DIV0 (`PBS_CLK_KHZ / `PBS_RATE0_KHZ)
`define PBS_DIV1 (`PBS_CLK_KHZ / `PBS_RATE1_KHZ)
`define PBS_DIV2 (`PBS_CLK_KHZ / `PBS_RATE2_KHZ)
`define PBS_DIV3 (`PBS_CLK_KHZ / `PBS_RATE3_KHZ)
`endif

// File: hdl/pbs_pkg.sv
// Types of the banked status and control register group
`include "pbs_defines.svh"
package pbs_pkg;
  typedef struct packed {
    logic done;
    logic present;
    logic fcs_ok;
    logic [15:0] temp;
  } pbs_result_t;

  typedef struct packed {
    logic [7:0] agent_cfg;
    logic [3:0][6:0] temperature_reference;
    logic [7:0] domain;
  } pbs_cfg_t;

  typedef struct packed {
    logic [7:0] agent_cfg;
    logic [3:0][6:0] tref;
    logic [7:0] domain;
    logic bank;
    logic [1:0] speed;
    logic [3:0][2:0] fcs_hist;
    logic [3:0] absent;
    logic [3:0][15:0] rel_temp;
    logic [7:0] status;
    logic [7:0] mask;
    logic [1:0] agent_ptr;
    logic [7:0] target;
    logic [9:0] div_cnt;
    logic tick;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
  } pbs_state_t;

  localparam pbs_state_t PBS_RESET = '{
    agent_cfg: `PBS_RST_CFG,
    tref: {4{`PBS_RST_TEMPERATURE_REFERENCE}},
    domain: `PBS_RST_DOM,
    bank: `PBS_RST_BANK,
    speed: `PBS_RST_SPEED,
    fcs_hist: '0,
    absent: '0,
    rel_temp: '0,
    status: 8'h00,
    mask: 8'h00,
    agent_ptr: 2'h0,
    target: `PBS_AGENT_BASE,
    div_cnt: 10'h000,
    tick: 1'b0,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0,
    irq: 1'b0
  };
endpackage

// File: hdl/pbs_regs.sv
// Banked status and control registers of the agent temperature monitor
// Summary of operation
// - Agent 4 temperature low byte reads at E6h, valid with bank 1.
// - Agent 4 temperature high byte reads at E7h with bank 1.
// - In bank 0 each agent flag is 1 if a bad check sequence came in its last 3 answers.
// - In bank 1 each agent flag is 1 when the agent is not detected.
// - Flags sit at warning bits 7 to 4 for agents 4 down to 1.
// - Warning bit 3 selects the bank seen at E0h to E7h and the flag meaning.
// - Bank 1 maps agent temperatures as low/high pairs from E0/E1 to E6/E7.
// - Bank 0 maps config at E0, references at E1 to E4, domain at E5, E6/E7 reserved.
// - Speed bits 1:0 set the bit rate 1.5 MHz, 750, 375 or 187 KHz.
// - Warning register resets to zero, bit 2 is reserved.
// - Agents 1 to 4 are addressed at targets 30h to 33h.
`timescale 1ns/100ps
`include "pbs_defines.svh"

module pbs_regs import pbs_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link engine
  input wire pbs_result_t result,
  output logic [7:0] target_addr,
  output logic bit_tick,
  output pbs_cfg_t cfg,
  // Interrupt
  output logic irq
);

  pbs_state_t s;
  pbs_state_t next_s;

  logic [7:0] idx;
  logic hit;
  logic setup;
  logic wr;
  logic [3:0] alert_now;
  logic [3:0] alert_new;
  logic [7:0] events;
  logic [7:0] clr;
  logic [7:0] rd_byte;
  logic [1:0] pa;
  logic [1:0] ka;

  function automatic logic [9:0] div_load(input logic [1:0] sp);
    case (sp)
      2'h0: div_load = 10'(`PBS_DIV0 - 1);
      2'h1: div_load = 10'(`PBS_DIV1 - 1);
      2'h2: div_load = 10'(`PBS_DIV2 - 1);
      default: div_load = 10'(`PBS_DIV3 - 1);
    endcase
  endfunction

  always_comb begin
    next_s = s;
    idx = paddr[9:2];
    hit = (paddr[11:10] == 2'h0) && (idx >= `PBS_IDX_CFG) && (idx <= `PBS_IDX_MASK);
    setup = psel && !penable;
    wr = psel && penable && s.ready && pwrite;
    pa = s.agent_ptr;
    ka = idx[2:1];
    clr = 8'h00;
    rd_byte = 8'h00;

    // Bit-rate enable; reload picks up a new speed at the next period
    next_s.tick = 1'b0;
    if (s.div_cnt == 10'h000) begin
      next_s.div_cnt = div_load(s.speed);
      next_s.tick = 1'b1;
    end else begin
      next_s.div_cnt = s.div_cnt - 10'h001;
    end

    // Results of the link engine belong to the agent now addressed
    if (result.done) begin
      next_s.absent[pa] = !result.present;
      if (result.present) begin
        next_s.fcs_hist[pa] = {s.fcs_hist[pa][1:0], !result.fcs_ok};
        if (result.fcs_ok) begin
          next_s.rel_temp[pa] = result.temp;
        end
      end
      next_s.agent_ptr = s.agent_ptr + 2'h1;
    end
    next_s.target = `PBS_AGENT_BASE + {6'h00, next_s.agent_ptr};

    for (int i = 0; i < 4; i++) begin
      alert_now[i] = |s.fcs_hist[i];
      alert_new[i] = |next_s.fcs_hist[i];
    end
    events = {alert_new & ~alert_now, next_s.absent & ~s.absent};

    // Read path, sampled in the setup cycle
    case (idx)
      `PBS_IDX_WARN: begin
        // Reserved bit 2 reads zero
        rd_byte = {s.bank ? s.absent : alert_now, s.bank, 1'b0, s.speed};
      end
      `PBS_IDX_STAT: rd_byte = s.status;
      `PBS_IDX_MASK: rd_byte = s.mask;
      default: begin
        if (s.bank) begin
          // Pairs E0/E1 to E6/E7, low byte at the even index
          rd_byte = idx[0] ? s.rel_temp[ka][15:8] : s.rel_temp[ka][7:0];
        end else if (idx == `PBS_IDX_CFG) begin
          rd_byte = s.agent_cfg;
        end else if (idx >= `PBS_IDX_TB1 && idx <= `PBS_IDX_TB4) begin
          rd_byte = {1'b0, s.tref[2'(idx - `PBS_IDX_TB1)]};
        end else if (idx == `PBS_IDX_DOM) begin
          rd_byte = s.domain;
        end
      end
    endcase

    next_s.ready = setup;
    next_s.slverr = setup && !hit;
    if (setup) begin
      next_s.rdata = hit ? {24'h000000, rd_byte} : 32'h0000_0000;
    end

    // Writes take effect at the completing access edge
    if (wr && hit) begin
      case (idx)
        `PBS_IDX_WARN: begin
          // Flag bits are owned by hardware; writes to them are dropped
          next_s.bank = pwdata[`PBS_BANK_BIT];
          next_s.speed = pwdata[`PBS_SPEED_MSB:`PBS_SPEED_LSB];
        end
        `PBS_IDX_STAT: clr = pwdata[7:0];
        `PBS_IDX_MASK: next_s.mask = pwdata[7:0];
        default: begin
          // Bank 1 locations are read-only and shield the bank 0 registers
          if (!s.bank) begin
            if (idx == `PBS_IDX_CFG) begin
              next_s.agent_cfg = pwdata[7:0];
            end else if (idx >= `PBS_IDX_TB1 && idx <= `PBS_IDX_TB4) begin
              next_s.tref[2'(idx - `PBS_IDX_TB1)] = pwdata[6:0];
            end else if (idx == `PBS_IDX_DOM) begin
              next_s.domain = pwdata[7:0] & `PBS_DOM_WMASK;
            end
          end
        end
      endcase
    end

    // A new event beats a clear in the same cycle
    next_s.status = (s.status & ~clr) | events;
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= PBS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;
  assign target_addr = s.target;
  assign bit_tick = s.tick;
  assign irq = s.irq;
  assign cfg = '{agent_cfg: s.agent_cfg, temperature_reference: s.tref, domain: s.domain};

endmodule

// File: verif/pbs_assertions.sv
// Port checks of the register group
`timescale 1ns/100ps
module pbs_assertions import pbs_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link and config
  input wire pbs_result_t result,
  input wire logic [7:0] target_addr,
  input wire logic bit_tick,
  input wire pbs_cfg_t cfg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_ready_one: assert property (psel && !penable |=> pready)
    else $error("ready late");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready long");
  a_err_zero: assert property (pslverr |-> pready && prdata == 0)
    else $error("error data");
  a_unmapped_err: assert property (psel && !penable && paddr[9:2] > 8'hea |=> pslverr)
    else $error("no error");
  a_target_next: assert property (result.done |=>
    target_addr == {6'h0c, $past(target_addr[1:0]) + 2'h1}) else $error("target step");
  a_target_hold: assert property (!result.done |=> $stable(target_addr))
    else $error("target moved");
  a_tick_gap: assert property (bit_tick |=> !bit_tick [*8])
    else $error("tick gap");
  a_cfg_hold: assert property (!(psel && penable && pwrite) |=> $stable(cfg))
    else $error("cfg moved");
endmodule
bind pbs_regs pbs_assertions pbs_assertions_inst (.*);

// File: verif/pbs_agent_model.sv
// Agent model answering polls
`timescale 1ns/100ps
module pbs_agent_model import pbs_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Poll: go, mode = present and good check
  input wire logic go,
  input wire logic [1:0] mode,
  input wire logic [7:0] target_addr,
  // Answer
  output pbs_result_t result
);
  // High byte echoes the address; temp toggles outside answers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= '0;
    end else begin
      result <= '{go, mode[1], &mode, go ? {target_addr, 8'h5a} : ~result.temp};
    end
  end
endmodule

// File: verif/tb_top.sv
// Bench for the register group
`timescale 1ns/100ps
module tb_top import pbs_pkg::*;;
  logic ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic er, irq, bit_tick, pready, pslverr;
  logic [1:0] mode = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [7:0] target_addr;
  pbs_result_t result;
  int n_fail = 0, cmp_count = 0, cyc = 0, n;
  int dv[4] = '{66, 133, 266, 534};
  initial forever #5 ref_clk = ~ref_clk;
  pbs_regs pbs_regs_inst (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .result, .target_addr, .bit_tick, .cfg(), .irq);
  pbs_agent_model pbs_agent_model_inst (.ref_clk, .arst_n, .go, .mode, .target_addr,
    .result);
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1);
    r = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    xfer(0, i, 0);
    chk(r, {24'h0, e});
  endtask
  // One poll per agent, spaced so each answer lands on its own target
  task automatic round(input logic [7:0] m);
    for (int k = 0; k < 4; k++) begin
      mode <= m[2*k+:2];
      go <= 1;
      @(posedge ref_clk);
      go <= 0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1;
    rd(8'he8, 8'h00);
    rd(8'he1, 8'h48);
    round(8'hff);
    xfer(1, 8'he8, 8'hff);
    rd(8'he8, 8'h0b);
    for (int k = 0; k < 4; k++) begin
      rd(8'he0 + 8'(2*k), 8'h5a);
      rd(8'he1 + 8'(2*k), 8'h30 + 8'(k));
    end
    xfer(1, 8'he6, 8'h00);
    xfer(1, 8'he0, 8'hff);
    rd(8'he6, 8'h5a);
    rd(8'he7, 8'h33);
    xfer(1, 8'he8, 8'h00);
    rd(8'he0, 8'h00);
    rd(8'he6, 8'h00);
    xfer(1, 8'he1, 8'hff);
    rd(8'he1, 8'h7f);
    xfer(1, 8'hea, 8'hff);
    round(8'hfe);
    rd(8'he8, 8'h10);
    chk(irq, 1);
    xfer(1, 8'he9, 8'hff);
    rd(8'he9, 8'h00);
    chk(irq, 0);
    round(8'hff);
    round(8'hff);
    rd(8'he8, 8'h10);
    round(8'hff);
    rd(8'he8, 8'h00);
    round(8'h3f);
    xfer(1, 8'he8, 8'h08);
    rd(8'he8, 8'h88);
    chk(irq, 1);
    xfer(0, 8'heb, 8'h00);
    chk(er, 1);
    for (int s = 0; s < 4; s++) begin
      xfer(1, 8'he8, 8'(s));
      repeat (2) @(posedge ref_clk iff bit_tick);
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (bit_tick !== 1);
      chk(n, dv[s]);
    end
    end_of_test();
  end
endmodule
